// ---- core/pfs_pkg.sv ----
// Constants shared by the frequency synthesiser control files
package pfs_pkg;
	localparam logic [31:0] BASE_SYS = 32'h4002_8000;
	localparam logic [31:0] BASE_USB = 32'h4002_c000;
	localparam logic [1:0] IDX_CTRL = 2'h0;
	localparam logic [1:0] IDX_POWER = 2'h1;
	localparam logic [1:0] IDX_FB = 2'h2;
	localparam logic [1:0] IDX_POST = 2'h3;
	localparam int CTRL_LOCK_BIT = 31;
	localparam int CTRL_BYPASS_BIT = 8;
	localparam int REFDIV_W = 6;
	localparam int POWER_OSC_BIT = 5;
	localparam int POWER_OUTDIV_BIT = 3;
	localparam int POWER_MOD_BIT = 2;
	localparam int POWER_MAIN_BIT = 0;
	localparam int FB_W = 12;
	localparam int PDIV_W = 3;
	localparam int PD1_LSB = 16;
	localparam int PD2_LSB = 12;
	localparam logic [REFDIV_W-1:0] REFDIV_RST = 6'h01;
	localparam logic BYPASS_RST = 1'b0;
	localparam logic POWER_BIT_RST = 1'b1;
	localparam logic [FB_W-1:0] FBDIV_RST = 12'h000;
	localparam logic [PDIV_W-1:0] PDIV_RST = 3'h7;
	localparam int PER_W = 16;
	localparam int LOCK_PERIODS = 8;
	typedef enum logic [2:0] {
		LK_OFF = 3'b001,
		LK_SETTLE = 3'b010,
		LK_ON = 3'b100
	} pfs_lock_type;
endpackage

// ---- core/pfs_div_if.sv ----
// Link between the oscillator model and the post divider chain
interface pfs_div_if #(parameter int PDIV_W = 3);
	logic tick_in;
	logic [PDIV_W-1:0] div1;
	logic [PDIV_W-1:0] div2;
	logic power_down;
	logic tick_out;
	modport ctrl (output tick_in, output div1, output div2, output power_down, input tick_out);
	modport div (input tick_in, input div1, input div2, input power_down, output tick_out);
endinterface

// ---- core/pfs_post_div.sv ----
// Two cascaded post dividers acting on oscillator tick pulses
module pfs_post_div #(parameter int PDIV_W = 3) (
	input wire logic clk,
	input wire logic sys_rst,
	pfs_div_if.div dv
);
	logic [PDIV_W-1:0] c1_r;
	logic [PDIV_W-1:0] c2_r;
	logic s1_r;
	logic out_r;
	wire logic s1_end = dv.tick_in && (c1_r + 1'b1 >= dv.div1);
	wire logic s2_end = s1_r && (c2_r + 1'b1 >= dv.div2);

	// First stage feeds the second; a zero value acts as divide by one
	always_ff @(posedge clk) begin
		if (sys_rst || dv.power_down) begin
			c1_r <= '0;
			c2_r <= '0;
			s1_r <= 1'b0;
			out_r <= 1'b0;
		end else begin
			if (dv.tick_in) c1_r <= s1_end ? '0 : c1_r + 1'b1;
			s1_r <= s1_end;
			if (s1_r) c2_r <= s2_end ? '0 : c2_r + 1'b1;
			out_r <= s2_end;
		end
	end
	assign dv.tick_out = out_r;

	stage1_count_a: assert property (@(posedge clk) disable iff (sys_rst)
		(dv.tick_in && !dv.power_down && c1_r == dv.div1 - 1'b1) |=> s1_r)
		else $error("first divider missed its terminal count");
	out_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_r |-> $past(s1_r) && !$past(dv.power_down))
		else $error("output pulse without a first divider pulse");
endmodule

// ---- core/pfs_ctrl.sv ----
// Two frequency synthesiser instances with register decode and lock tracking
module pfs_ctrl #(
	parameter int LOCK_PERIODS = pfs_pkg::LOCK_PERIODS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic crystal_input_pin,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata,
	output logic [1:0] synth_out_en,
	output logic [1:0] lock_out
);
	localparam int PW = pfs_pkg::PER_W;
	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_s3_r;
	logic pin_lvl_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_word [2];
	logic [1:0] hit;

	// Crystal pin synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
			pin_lvl_r <= 1'b0;
		end else begin
			pin_s1_r <= crystal_input_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			if (pin_s2_r == pin_s3_r) pin_lvl_r <= pin_s3_r;
		end
	end
	wire logic ref_edge = (pin_s2_r == pin_s3_r) && pin_s3_r && !pin_lvl_r;

	// Read data is registered; unmapped addresses answer zero
	wire logic [31:0] rd_mux = hit[0] ? rd_word[0] : (hit[1] ? rd_word[1] : 32'h0000_0000);
	always_ff @(posedge clk) begin
		if (sys_rst) rdata_r <= 32'h0000_0000;
		else if (bus_rd) rdata_r <= rd_mux;
	end
	assign bus_rdata = rdata_r;

	unmapped_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_rd && hit == 2'b00) |=> bus_rdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");

	for (genvar i = 0; i < 2; i++) begin : g_inst
		localparam logic [31:0] BASE = (i == 0) ? pfs_pkg::BASE_SYS : pfs_pkg::BASE_USB;
		logic [pfs_pkg::REFDIV_W-1:0] refdiv_r;
		logic bypass_r;
		logic main_off_r;
		logic mod_off_r;
		logic outdiv_off_r;
		logic osc_off_r;
		logic [pfs_pkg::FB_W-1:0] fbdiv_r;
		logic [pfs_pkg::PDIV_W-1:0] pd1_r;
		logic [pfs_pkg::PDIV_W-1:0] pd2_r;
		logic [pfs_pkg::REFDIV_W-1:0] rcnt_r;
		logic [PW-1:0] pcnt_r;
		logic [PW-1:0] per_r;
		logic [PW:0] acc_r;
		logic [3:0] scnt_r;
		logic out_r;
		pfs_pkg::pfs_lock_type lk_r;
		pfs_pkg::pfs_lock_type lk_nxt;
		pfs_div_if #(.PDIV_W(pfs_pkg::PDIV_W)) dv ();

		// Address decode for this instance's four words
		assign hit[i] = bus_addr[31:4] == BASE[31:4];
		wire logic [1:0] widx = bus_addr[3:2];
		wire logic wr_ctrl = bus_wr && hit[i] && widx == pfs_pkg::IDX_CTRL;
		wire logic wr_power = bus_wr && hit[i] && widx == pfs_pkg::IDX_POWER;
		wire logic wr_fb = bus_wr && hit[i] && widx == pfs_pkg::IDX_FB;
		wire logic wr_post = bus_wr && hit[i] && widx == pfs_pkg::IDX_POST;
		wire logic lock_q = lk_r == pfs_pkg::LK_ON;
		wire logic cfg_chg = (wr_ctrl && bus_wdata[pfs_pkg::REFDIV_W-1:0] != refdiv_r) ||
			(wr_fb && bus_wdata[pfs_pkg::FB_W-1:0] != fbdiv_r);

		// Register file; reserved bits are not stored and read as zero
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				refdiv_r <= pfs_pkg::REFDIV_RST;
				bypass_r <= pfs_pkg::BYPASS_RST;
				main_off_r <= pfs_pkg::POWER_BIT_RST;
				mod_off_r <= pfs_pkg::POWER_BIT_RST;
				outdiv_off_r <= pfs_pkg::POWER_BIT_RST;
				osc_off_r <= pfs_pkg::POWER_BIT_RST;
				fbdiv_r <= pfs_pkg::FBDIV_RST;
				pd1_r <= pfs_pkg::PDIV_RST;
				pd2_r <= pfs_pkg::PDIV_RST;
			end else begin
				if (wr_ctrl) begin
					refdiv_r <= bus_wdata[pfs_pkg::REFDIV_W-1:0];
					bypass_r <= bus_wdata[pfs_pkg::CTRL_BYPASS_BIT];
				end
				if (wr_power) begin
					main_off_r <= bus_wdata[pfs_pkg::POWER_MAIN_BIT];
					mod_off_r <= bus_wdata[pfs_pkg::POWER_MOD_BIT];
					outdiv_off_r <= bus_wdata[pfs_pkg::POWER_OUTDIV_BIT];
					osc_off_r <= bus_wdata[pfs_pkg::POWER_OSC_BIT];
				end
				if (wr_fb) fbdiv_r <= bus_wdata[pfs_pkg::FB_W-1:0];
				if (wr_post) begin
					pd1_r <= bus_wdata[pfs_pkg::PD1_LSB +: pfs_pkg::PDIV_W];
					pd2_r <= bus_wdata[pfs_pkg::PD2_LSB +: pfs_pkg::PDIV_W];
				end
			end
		end

		// Read words; lock is read-only and writes to it are dropped
		always_comb begin
			rd_word[i] = 32'h0000_0000;
			unique case (widx)
				pfs_pkg::IDX_CTRL: begin
					rd_word[i][pfs_pkg::CTRL_LOCK_BIT] = lock_q;
					rd_word[i][pfs_pkg::CTRL_BYPASS_BIT] = bypass_r;
					rd_word[i][pfs_pkg::REFDIV_W-1:0] = refdiv_r;
				end
				pfs_pkg::IDX_POWER: begin
					rd_word[i][pfs_pkg::POWER_OSC_BIT] = osc_off_r;
					rd_word[i][pfs_pkg::POWER_OUTDIV_BIT] = outdiv_off_r;
					rd_word[i][pfs_pkg::POWER_MOD_BIT] = mod_off_r;
					rd_word[i][pfs_pkg::POWER_MAIN_BIT] = main_off_r;
				end
				pfs_pkg::IDX_FB: rd_word[i][pfs_pkg::FB_W-1:0] = fbdiv_r;
				pfs_pkg::IDX_POST: begin
					rd_word[i][pfs_pkg::PD1_LSB +: pfs_pkg::PDIV_W] = pd1_r;
					rd_word[i][pfs_pkg::PD2_LSB +: pfs_pkg::PDIV_W] = pd2_r;
				end
			endcase
		end

		// Reference divider; divisor zero is undefined and behaves as one
		wire logic ref_tick = ref_edge && (rcnt_r + 1'b1 >= refdiv_r);
		wire logic [PW-1:0] pcnt_inc = (&pcnt_r) ? pcnt_r : pcnt_r + 1'b1;
		wire logic [PW-1:0] per_diff = (pcnt_inc > per_r) ? pcnt_inc - per_r : per_r - pcnt_inc;
		wire logic per_same = per_diff <= PW'(1);
		// Oscillator model runs only with main block and oscillator powered up
		wire logic running = !main_off_r && !osc_off_r && per_r != '0;
		wire logic [PW:0] acc_sum = acc_r + (PW+1)'(fbdiv_r);
		wire logic vco_tick = running && acc_sum >= {1'b0, per_r};

		// Period detector and numerically controlled oscillator form the loop
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				rcnt_r <= '0;
				pcnt_r <= '0;
				per_r <= '0;
				acc_r <= '0;
			end else begin
				if (ref_edge) rcnt_r <= ref_tick ? '0 : rcnt_r + 1'b1;
				pcnt_r <= ref_tick ? '0 : pcnt_inc;
				if (ref_tick) per_r <= pcnt_inc;
				if (!running) acc_r <= '0;
				else acc_r <= vco_tick ? acc_sum - {1'b0, per_r} : acc_sum;
			end
		end

		// Lock tracker: settles after a run of steady divided reference periods
		always_comb begin
			lk_nxt = lk_r;
			unique case (lk_r)
				pfs_pkg::LK_OFF: if (running) lk_nxt = pfs_pkg::LK_SETTLE;
				pfs_pkg::LK_SETTLE: begin
					if (ref_tick && per_same && scnt_r == 4'(LOCK_PERIODS - 1))
						lk_nxt = pfs_pkg::LK_ON;
				end
				pfs_pkg::LK_ON: if (ref_tick && !per_same) lk_nxt = pfs_pkg::LK_SETTLE;
				default: lk_nxt = pfs_pkg::LK_OFF;
			endcase
			if (!running || cfg_chg) lk_nxt = pfs_pkg::LK_OFF;
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				lk_r <= pfs_pkg::LK_OFF;
				scnt_r <= '0;
			end else begin
				lk_r <= lk_nxt;
				if (lk_nxt != pfs_pkg::LK_SETTLE || (ref_tick && !per_same)) scnt_r <= '0;
				else if (ref_tick) scnt_r <= scnt_r + 1'b1;
			end
		end

		// Post dividers stay silent while powered down or the oscillator is off
		assign dv.tick_in = vco_tick;
		assign dv.div1 = pd1_r;
		assign dv.div2 = pd2_r;
		assign dv.power_down = outdiv_off_r || !running;
		pfs_post_div #(.PDIV_W(pfs_pkg::PDIV_W)) u_post (
			.clk(clk),
			.sys_rst(sys_rst),
			.dv(dv)
		);

		// Bypass swaps sources abruptly, so a glitch on the switch is expected
		always_ff @(posedge clk) begin
			if (sys_rst) out_r <= 1'b0;
			else out_r <= bypass_r ? ref_edge : dv.tick_out;
		end
		assign synth_out_en[i] = out_r;
		assign lock_out[i] = lock_q;

		refdiv_rst_a: assert property (@(posedge clk) sys_rst |=>
			refdiv_r == pfs_pkg::REFDIV_RST && !lock_q)
			else $error("reference divisor or lock wrong after reset");
		power_rst_a: assert property (@(posedge clk) sys_rst |=>
			main_off_r && mod_off_r && outdiv_off_r && osc_off_r)
			else $error("power-down bits not set after reset");
		postdiv_rst_a: assert property (@(posedge clk) sys_rst |=>
			pd1_r == pfs_pkg::PDIV_RST && pd2_r == pfs_pkg::PDIV_RST)
			else $error("post dividers not seven after reset");
		lock_powered_a: assert property (@(posedge clk) disable iff (sys_rst)
			(main_off_r || osc_off_r) |=> !lock_q)
			else $error("lock reported while powered down");
		lock_cfg_a: assert property (@(posedge clk) disable iff (sys_rst)
			cfg_chg |=> !lock_q ##1 !lock_q)
			else $error("lock held across a divisor change");
		vco_loop_a: assert property (@(posedge clk) disable iff (sys_rst)
			vco_tick |-> !main_off_r && !osc_off_r && acc_r < {1'b0, per_r} + (PW+1)'(fbdiv_r))
			else $error("oscillator tick without a running loop");
		bypass_path_a: assert property (@(posedge clk) disable iff (sys_rst)
			(bypass_r && !wr_ctrl) |=> out_r == $past(ref_edge))
			else $error("bypass output does not follow the reference");
		fb_readback_a: assert property (@(posedge clk) disable iff (sys_rst)
			(bus_rd && hit[i] && widx == pfs_pkg::IDX_FB) |=>
			bus_rdata == {20'h0_0000, $past(fbdiv_r)})
			else $error("feedback divisor readback mismatch");
	end
endmodule

// ---- tb/pfs_xtal_model.sv ----
// Free-running reference crystal model feeding the synthesiser pin
module pfs_xtal_model #(
	parameter int HALF = 20
) (
	input wire logic clk,
	output logic crystal_input_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial crystal_input_pin = 1'b0;
	// Steady period; a crystal never stops, so no idle gaps are modelled
	always @(negedge clk) begin
		cnt = (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == 0) begin
			crystal_input_pin <= ~crystal_input_pin;
		end
	end
endmodule

// ---- tb/testbench.sv ----
// Register and clock-output checks for both synthesiser instances
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] S = pfs_pkg::BASE_SYS;
	localparam logic [31:0] U = pfs_pkg::BASE_USB;
	logic clk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, xtal, xtal_q = 1'b0;
	logic cnt_en = 1'b0, sel = 1'b0;
	logic [31:0] bus_addr = 32'h0000_0000, bus_wdata = 32'h0000_0000, bus_rdata, b;
	logic [1:0] synth_out_en, lock_out;
	int fails = 0, comparisons = 0, pulses, rises, i;
	always #50 clk = ~clk;
	pfs_xtal_model #(.HALF(20)) pfs_xtal_model_inst (.clk(clk), .crystal_input_pin(xtal));
	// Short lock count keeps the run brief
	pfs_ctrl #(.LOCK_PERIODS(2)) pfs_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
		.crystal_input_pin(xtal), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .synth_out_en(synth_out_en),
		.lock_out(lock_out));
	// Pulse and reference edge counters for rate checks
	always @(posedge clk) begin
		xtal_q <= xtal;
		if (cnt_en) begin
			pulses += synth_out_en[sel];
			rises += (xtal & ~xtal_q);
		end
	end
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask
	// Read data is registered, so it is settled at the next falling edge
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		`CHK(nm, e, bus_rdata)
	endtask
	task automatic count(input int n);
		pulses = 0;
		rises = 0;
		cnt_en = 1'b1;
		repeat (n) @(negedge clk);
		cnt_en = 1'b0;
	endtask
	task automatic wlock;
		i = 0;
		while (lock_out[0] !== 1'b1 && i < 3000) begin
			@(negedge clk);
			i++;
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard, well beyond the expected few thousand cycles
	initial begin
		#2_000_000;
		fails++;
		complete_run();
	end
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		`CHK("lock_rst", 2'b00, lock_out)
		for (int k = 0; k < 2; k++) begin
			b = (k == 0) ? S : U;
			rd(b, 32'h0000_0001, "ctrl_rst");
			rd(b + 32'h4, 32'h0000_002D, "power_rst");
			rd(b + 32'h8, 32'h0000_0000, "fb_rst");
			rd(b + 32'hC, 32'h0007_7000, "post_rst");
		end
		rd(32'h4003_0000, 32'h0000_0000, "unmapped");
		// Lock and reserved bits must not stick; bypass on the second instance
		wr(U, 32'hFFFF_FFFF);
		rd(U, 32'h0000_013F, "ctrl_mask");
		rd(S, 32'h0000_0001, "ctrl_other");
		sel = 1'b1;
		count(400);
		`CHK("bypass", 1'b1, (pulses - rises <= 1) && (rises - pulses <= 1))
		wr(U, 32'h0000_0001);
		// Divided reference period 80 clocks, oscillator half a tick per clock
		sel = 1'b0;
		wr(S, 32'h0000_0002);
		wr(S + 32'h8, 32'h0000_0028);
		wr(S + 32'h4, 32'h0000_000C);
		wlock();
		`CHK("lock", 2'b01, lock_out)
		rd(S, 32'h8000_0002, "ctrl_lock");
		wr(S + 32'hC, 32'h0002_1000);
		wr(S + 32'h4, 32'h0000_0004);
		rd(S + 32'hC, 32'h0002_1000, "post_rb");
		rd(S + 32'h4, 32'h0000_0004, "power_rb");
		count(1600);
		`CHK("out_rate", 1'b1, pulses >= 396 && pulses <= 404)
		wr(S + 32'h8, 32'h0000_0029);
		repeat (2) @(negedge clk);
		`CHK("fb_drop", 1'b0, lock_out[0])
		rd(S + 32'h8, 32'h0000_0029, "fb_rb");
		wlock();
		`CHK("relock", 1'b1, lock_out[0])
		wr(S + 32'h4, 32'h0000_000D);
		repeat (2) @(negedge clk);
		`CHK("off_drop", 1'b0, lock_out[0])
		count(400);
		`CHK("off_quiet", 0, pulses)
		`CHK("off_idle", 2'b00, synth_out_en)
		complete_run();
	end
endmodule
